// ---- bench/fw_tgt_model.sv ----
`timescale 1ns/1ps
module fw_tgt_model
  import fw_host_pkg::*;
(
  input  wire logic               i_ref_clk,    // bus clock
  input  wire logic               i_frame_n,    // host frame level
  input  wire logic               i_frame_oe_n, // host frame enable
  input  wire logic               i_irdy_n,     // host irdy level
  input  wire logic               i_irdy_oe_n,  // host irdy enable
  input  wire logic [31:0]        i_ad,         // host address/data
  input  wire logic               i_ad_oe_n,    // host ad enable
  input  wire logic [3:0]         i_cbe_n,      // host command
  input  wire fw_host_pkg::term_t i_mode,       // ending to signal
  input  wire logic [3:0]         i_waits,      // waitstates per point
  input  wire logic               i_wbf_n,      // buffer full level
  output      fw_host_pkg::tgt_pins_t o_tgt,    // target pins
  output      logic [31:0]        o_addr,       // last address seen
  output      logic [3:0]         o_cmd         // last command seen
);
  import fw_host_pkg::*;

  // ****************************************
  // wire levels
  // ****************************************
  logic        frame_w;
  logic        irdy_w;
  logic [31:0] ad_w;
  logic        f_smp;
  logic        i_smp;
  logic [31:0] d_smp;
  logic [3:0]  c_smp;
  logic        devsel_n;
  logic        trdy_n;
  logic        stop_n;
  logic        claim;
  logic        stopping;
  logic        done;
  term_t       md;
  int          n;
  logic [31:0] got [$];

  // control lines have pull-ups; a released ad bus must not look stale
  assign frame_w = i_frame_oe_n ? 1'b1 : i_frame_n;
  assign irdy_w  = i_irdy_oe_n ? 1'b1 : i_irdy_n;
  assign ad_w    = i_ad_oe_n ? ~i_ad : i_ad;
  assign o_tgt   = {devsel_n, trdy_n, stop_n, i_wbf_n};

  // ****************************************
  // target behaviour
  // ****************************************
  task automatic tick();
    @(posedge i_ref_clk);
    f_smp = frame_w;
    i_smp = irdy_w;
    d_smp = ad_w;
    c_smp = i_cbe_n;
    #1;
  endtask

  // a word rides only on a clock with its byte enables on
  task automatic take();
    if (claim && c_smp == BE_ALL_N) begin
      got.push_back(d_smp);
    end
  endtask

  initial begin
    devsel_n = 1'b1;
    trdy_n = 1'b1;
    stop_n = 1'b1;
    claim = 1'b0;
    o_addr = ADDR_RST;
    o_cmd = 4'hF;
    forever begin
      do tick(); while (f_smp !== 1'b0);
      o_addr = d_smp;
      o_cmd = c_smp;
      md = i_mode;
      claim = (md != TERM_MST_ABORT);
      devsel_n = !claim;
      stopping = 1'b0;
      done = 1'b0;
      while (!done) begin
        do tick(); while (i_smp !== 1'b0 && f_smp !== 1'b1);
        if (i_smp !== 1'b0) begin
          done = 1'b1;
        end else begin
          take();
          n = 1;
          while (n < 4 && f_smp !== 1'b1) begin
            tick();
            take();
            n++;
          end
          if (f_smp === 1'b1) begin
            done = 1'b1;
          end else begin
            repeat (i_waits) tick();
            if (stopping || md != TERM_NORMAL && md != TERM_DISC_DATA) begin
              if (md == TERM_DISC_NODATA) begin
                stop_n = 1'b0;
              end else if (md == TERM_TGT_ABORT) begin
                devsel_n = 1'b1;
                stop_n = 1'b0;
              end
              while (f_smp !== 1'b1) tick();
              done = 1'b1;
            end else begin
              trdy_n = 1'b0;
              stop_n = (md != TERM_DISC_DATA);
              stopping = !stop_n;
              tick();
              trdy_n = 1'b1;
              tick();
            end
          end
        end
      end
      stop_n = 1'b1;
      devsel_n = 1'b1;
      trdy_n = 1'b1;
      claim = 1'b0;
    end
  end
endmodule

// ---- bench/tb_fw_host.sv ----
`timescale 1ns/1ps
module tb_fw_host;
  import fw_host_pkg::*;

  // ****************************************
  // signals and cases
  // ****************************************
  typedef struct {
    term_t mode;
    int    waits;
    int    nw;
    term_t term;
    int    ncons;
    int    nacc;
  } row_t;

  logic        i_ref_clk;
  logic        i_rst_n;
  logic [31:0] i_addr;
  logic        i_addr_load;
  logic [31:0] i_wr_data;
  logic        i_wr_valid;
  logic        o_wr_ready;
  tgt_pins_t   i_tgt;
  logic        o_frame_n;
  logic        o_frame_oe_n;
  logic        o_irdy_n;
  logic        o_irdy_oe_n;
  logic [31:0] o_ad;
  logic        o_ad_oe_n;
  logic [3:0]  o_cbe_n;
  logic        o_cbe_oe_n;
  term_t       o_term;
  logic        o_term_valid;
  term_t       mode;
  logic [3:0]  waits;
  logic        wbf_n;
  logic [31:0] seen_addr;
  logic [3:0]  seen_cmd;
  int          bad_count;
  int          num_checks;
  row_t        rows [9] = '{
    '{TERM_NORMAL, 0, 4, TERM_NORMAL, 4, 4},
    '{TERM_NORMAL, 2, 9, TERM_NORMAL, 9, 9},
    '{TERM_DISC_DATA, 0, 12, TERM_DISC_DATA, 8, 8},
    '{TERM_DISC_DATA, 1, 6, TERM_DISC_DATA, 6, 6},
    '{TERM_DISC_NODATA, 0, 8, TERM_DISC_NODATA, 4, 4},
    '{TERM_DISC_NODATA, 3, 5, TERM_DISC_NODATA, 4, 4},
    '{TERM_TGT_ABORT, 0, 8, TERM_TGT_ABORT, 4, 4},
    '{TERM_TGT_ABORT, 2, 6, TERM_TGT_ABORT, 4, 4},
    '{TERM_MST_ABORT, 0, 8, TERM_MST_ABORT, 4, 0}
  };

  fw_host #(.DEPTH(FIFO_DEPTH)) uut (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_addr_load(i_addr_load), .i_wr_data(i_wr_data),
    .i_wr_valid(i_wr_valid), .o_wr_ready(o_wr_ready), .i_tgt(i_tgt),
    .o_frame_n(o_frame_n), .o_frame_oe_n(o_frame_oe_n),
    .o_irdy_n(o_irdy_n), .o_irdy_oe_n(o_irdy_oe_n), .o_ad(o_ad),
    .o_ad_oe_n(o_ad_oe_n), .o_cbe_n(o_cbe_n), .o_cbe_oe_n(o_cbe_oe_n),
    .o_term(o_term), .o_term_valid(o_term_valid)
  );

  fw_tgt_model partner (
    .i_ref_clk(i_ref_clk), .i_frame_n(o_frame_n),
    .i_frame_oe_n(o_frame_oe_n), .i_irdy_n(o_irdy_n),
    .i_irdy_oe_n(o_irdy_oe_n), .i_ad(o_ad), .i_ad_oe_n(o_ad_oe_n),
    .i_cbe_n(o_cbe_n), .i_mode(mode), .i_waits(waits), .i_wbf_n(wbf_n),
    .o_tgt(i_tgt), .o_addr(seen_addr), .o_cmd(seen_cmd)
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h expected %h",
               $time, what, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic step();
    @(posedge i_ref_clk);
    #1;
  endtask

  function automatic logic [31:0] word(input int r, input int k);
    return 32'h5A00_0000 + 32'(r * 256 + k);
  endfunction

  task automatic set_addr(input logic [31:0] a);
    i_addr = a;
    i_addr_load = 1'b1;
    step();
    i_addr_load = 1'b0;
  endtask

  task automatic fill(input int r, input int n);
    int j;
    for (int k = 0; k < n; k++) begin
      i_wr_data = word(r, k);
      i_wr_valid = 1'b1;
      j = 0;
      while (o_wr_ready !== 1'b1 && j < 100) begin
        step();
        j++;
      end
      check(o_wr_ready, 1'b1, "room");
      step();
    end
    i_wr_valid = 1'b0;
  endtask

  // term_valid stands one cycle, so every cycle is looked at
  task automatic wait_term(input term_t exp, input logic [31:0] a);
    int j;
    j = 0;
    while (o_term_valid !== 1'b1 && j < 3000) begin
      step();
      j++;
    end
    check(o_term_valid, 1'b1, "end pulse");
    check(o_term, exp, "ending");
    check({o_frame_oe_n, o_irdy_oe_n, o_ad_oe_n, o_cbe_oe_n}, 4'hF,
          "released");
    check(seen_addr, a, "address");
    check(seen_cmd, CMD_MEM_WRITE, "command");
    step();
  endtask

  task automatic run_row(input int r);
    row_t        w;
    int          first;
    logic [31:0] base;
    w = rows[r];
    base = 32'h0001_0000 * 32'(r + 1);
    wbf_n = 1'b0;
    mode = w.mode;
    waits = 4'(w.waits);
    set_addr(base);
    fill(r, w.nw);
    repeat (4) step();
    check(o_frame_oe_n, 1'b1, "start while full");
    wbf_n = 1'b1;
    wait_term(w.term, base);
    mode = TERM_NORMAL;
    waits = 4'h0;
    if (w.nw > w.ncons) begin
      wait_term(TERM_NORMAL, base + 32'(w.ncons * 4));
    end
    check(partner.got.size(), w.nacc + w.nw - w.ncons, "count");
    first = (w.nacc == 0) ? w.ncons : 0;
    for (int k = first; k < w.nw; k++) begin
      check(partner.got.pop_front(), word(r, k), "data");
    end
  endtask

  // ****************************************
  // clock, watchdog and sequence
  // ****************************************
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  initial begin
    repeat (30000) @(posedge i_ref_clk);
    bad_count++;
    end_sim();
  end

  initial begin
    bad_count = 0;
    num_checks = 0;
    i_rst_n = 1'b0;
    i_addr = 32'h0;
    i_addr_load = 1'b0;
    i_wr_data = 32'h0;
    i_wr_valid = 1'b0;
    mode = TERM_NORMAL;
    waits = 4'h0;
    wbf_n = 1'b1;
    repeat (5) @(posedge i_ref_clk);
    #1;
    check({o_frame_oe_n, o_irdy_oe_n, o_ad_oe_n, o_cbe_oe_n}, 4'hF, "rst");
    check({o_frame_n, o_irdy_n, o_term_valid, o_wr_ready}, 4'hD, "rst");
    i_rst_n = 1'b1;
    repeat (3) step();
    for (int r = 0; r < 9; r++) begin
      run_row(r);
    end
    wbf_n = 1'b0;
    waits = 4'h3;
    set_addr(32'h0F00_0000);
    fill(15, FIFO_DEPTH);
    step();
    check(o_wr_ready, 1'b0, "full");
    i_wr_data = 32'hFFFF_0000;
    i_wr_valid = 1'b1;
    step();
    i_wr_valid = 1'b0;
    check(o_frame_oe_n, 1'b1, "start while full");
    wbf_n = 1'b1;
    wait_term(TERM_NORMAL, 32'h0F00_0000);
    check(partner.got.size(), FIFO_DEPTH, "drained");
    for (int k = 0; k < FIFO_DEPTH; k++) begin
      check(partner.got.pop_front(), word(15, k), "fifo order");
    end
    // a reset in mid-run must drop what the fifo holds
    wbf_n = 1'b0;
    set_addr(32'h0E00_0000);
    fill(16, 2);
    i_rst_n = 1'b0;
    step();
    check({o_frame_oe_n, o_wr_ready, o_term_valid}, 3'h6, "mid rst");
    i_rst_n = 1'b1;
    wbf_n = 1'b1;
    repeat (8) step();
    check({o_frame_oe_n, o_cbe_oe_n}, 2'h3, "fifo cleared");
    end_sim();
  end
endmodule

// ---- rtl/fw_fifo.sv ----
`timescale 1ns/1ps
module fw_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  input  wire logic                       i_ref_clk,  // bus clock
  input  wire logic                       i_rst_n,    // synced reset
  input  wire logic [W-1:0]               i_data,     // write word
  input  wire logic                       i_valid,    // word offered
  output      logic                       o_ready,    // room for a word
  output      logic [W-1:0]               o_data,     // head word
  output      logic                       o_valid,    // head present
  input  wire logic                       i_ready,    // head taken
  output      logic [$clog2(DEPTH+1)-1:0] o_count     // words held
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
    logic                    rdy;
  } fifo_st_t;

  fifo_st_t st_ff;
  fifo_st_t nxt_st;
  logic     push;
  logic     pop;

  assign push    = i_valid && st_ff.rdy;
  assign pop     = i_ready && (st_ff.cnt != '0);
  assign o_ready = st_ff.rdy;
  assign o_valid = (st_ff.cnt != '0);
  assign o_data  = st_ff.mem[st_ff.rp];
  assign o_count = st_ff.cnt;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = i_data;
      nxt_st.wp = (st_ff.wp == PW'(DEPTH-1)) ? '0 : st_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_st.rp = (st_ff.rp == PW'(DEPTH-1)) ? '0 : st_ff.rp + 1'b1;
    end
    if (push && !pop) begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end else if (pop && !push) begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end
    // ready is registered so the source sees a flop, not a compare
    nxt_st.rdy = (nxt_st.cnt != CW'(DEPTH));
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff     <= '0;
      st_ff.rdy <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  chk_fifo_full : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (st_ff.cnt == CW'(DEPTH)) |-> !o_ready)
    else $error("fifo offers room while full");

endmodule

// ---- rtl/fw_host.sv ----
`timescale 1ns/1ps
module fw_host
  import fw_host_pkg::*;
#(
  parameter int DEPTH = fw_host_pkg::FIFO_DEPTH
) (
  input  wire logic                      i_ref_clk,   // 10 MHz bus clock
  input  wire logic                      i_rst_n,     // async reset
  input  wire logic [31:0]               i_addr,      // start address
  input  wire logic                      i_addr_load, // load address
  input  wire logic [31:0]               i_wr_data,   // write word
  input  wire logic                      i_wr_valid,  // word offered
  output      logic                      o_wr_ready,  // fifo has room
  input  wire fw_host_pkg::tgt_pins_t    i_tgt,       // target pins
  output      logic                      o_frame_n,   // frame level
  output      logic                      o_frame_oe_n,// frame enable
  output      logic                      o_irdy_n,    // irdy level
  output      logic                      o_irdy_oe_n, // irdy enable
  output      logic [31:0]               o_ad,        // address/data
  output      logic                      o_ad_oe_n,   // ad enable
  output      logic [3:0]                o_cbe_n,     // command/enables
  output      logic                      o_cbe_oe_n,  // cbe enable
  output      fw_host_pkg::term_t        o_term,      // how it ended
  output      logic                      o_term_valid // end pulse
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    state_t     st;
    tgt_pins_t  s1;
    tgt_pins_t  s2;
    logic       frame_n;
    logic       frame_oe_n;
    logic       irdy_n;
    logic       irdy_oe_n;
    logic [31:0] ad;
    logic       ad_oe_n;
    logic [3:0] cbe_n;
    logic       cbe_oe_n;
    logic [31:0] addr;
    logic [3:0] cnt;
    logic [1:0] ign;
    logic [2:0] words;
    logic       last_blk;
    logic       dev_seen;
    term_t      term;
    logic       term_valid;
  } host_st_t;

  localparam logic [3:0] DEC_LIMIT = SLOW_DEC_CLK + SYNC_LAG;

  host_st_t   st_ff;
  host_st_t   nxt_st;
  logic [1:0] rst_sync_ff;
  logic       rst_n;
  logic [31:0] f_data;
  logic       f_valid;
  logic       f_pop;
  logic [$clog2(DEPTH+1)-1:0] f_count;
  logic       tp_live;
  logic       tp_abort;
  logic       tp_nodata;
  logic       tp_ready;
  logic       tp_mabort;
  logic       blk_end;

  // ****************************************
  // reset release
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  fw_fifo #(
    .W     (DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n),
    .i_data    (i_wr_data),
    .i_valid   (i_wr_valid),
    .o_ready   (o_wr_ready),
    .o_data    (f_data),
    .o_valid   (f_valid),
    .i_ready   (f_pop),
    .o_count   (f_count)
  );

  // ****************************************
  // throttle point decode on synced pins
  // ****************************************
  assign tp_live   = (st_ff.st == S_TP) && (st_ff.ign == 2'h0);
  // devsel dropped after a claim, stop low, trdy high
  assign tp_abort  = tp_live && st_ff.dev_seen && st_ff.s2.devsel_n &&
                     !st_ff.s2.stop_n && st_ff.s2.trdy_n;
  assign tp_nodata = tp_live && !tp_abort && !st_ff.s2.stop_n &&
                     st_ff.s2.trdy_n;
  assign tp_ready  = tp_live && !st_ff.s2.trdy_n;
  // never claimed by slow decode and no ready: nobody is there
  assign tp_mabort = tp_live && !st_ff.dev_seen && st_ff.s2.trdy_n &&
                     st_ff.s2.stop_n && (st_ff.cnt >= DEC_LIMIT);
  assign blk_end   = (st_ff.words == BLOCK_CLKS - 3'h1) ||
                     (f_count == 1);
  assign f_pop     = (st_ff.st == S_DATA) && f_valid;

  always_comb begin
    nxt_st            = st_ff;
    nxt_st.s1         = i_tgt;
    nxt_st.s2         = st_ff.s1;
    nxt_st.term_valid = 1'b0;
    if (st_ff.st != S_IDLE && st_ff.cnt != 4'hF) begin
      nxt_st.cnt = st_ff.cnt + 4'h1;
    end
    if (!st_ff.s2.devsel_n && st_ff.st != S_IDLE) begin
      nxt_st.dev_seen = 1'b1;
    end
    if (i_addr_load && st_ff.st == S_IDLE) begin
      nxt_st.addr = i_addr;
    end
    case (st_ff.st)
      S_IDLE: begin
        if (f_valid && st_ff.s2.wbf_n && !i_addr_load) begin
          nxt_st.st         = S_DATA;
          nxt_st.frame_n    = 1'b0;
          nxt_st.frame_oe_n = 1'b0;
          nxt_st.irdy_n     = 1'b1;
          nxt_st.irdy_oe_n  = 1'b0;
          nxt_st.ad         = st_ff.addr;
          nxt_st.ad_oe_n    = 1'b0;
          nxt_st.cbe_n      = CMD_MEM_WRITE;
          nxt_st.cbe_oe_n   = 1'b0;
          nxt_st.cnt        = 4'h0;
          nxt_st.words      = 3'h0;
          nxt_st.last_blk   = 1'b0;
          nxt_st.dev_seen   = 1'b0;
          nxt_st.term       = TERM_NORMAL;
        end
      end
      S_DATA: begin
        // data follows the address with no waitstate
        nxt_st.ad     = f_data;
        nxt_st.cbe_n  = BE_ALL_N;
        nxt_st.irdy_n = (st_ff.words != 3'h0);
        nxt_st.addr   = st_ff.addr + ADDR_STEP;
        nxt_st.words  = st_ff.words + 3'h1;
        if (blk_end) begin
          if (st_ff.last_blk) begin
            // one word: frame ends with irdy low, else with irdy high
            nxt_st.frame_n = 1'b1;
            nxt_st.st      = S_REL;
          end else begin
            nxt_st.st  = S_TP;
            nxt_st.ign = SYNC_LAG[1:0];
          end
        end
      end
      S_TP: begin
        nxt_st.irdy_n = 1'b1;
        nxt_st.cbe_n  = ~BE_ALL_N;  // short block: target sees no word here
        if (st_ff.ign != 2'h0) begin
          // drop pin samples still left over from the last point
          nxt_st.ign = st_ff.ign - 2'h1;
        end else if (tp_abort) begin
          nxt_st.term    = TERM_TGT_ABORT;
          nxt_st.frame_n = 1'b1;
          nxt_st.st      = S_REL;
        end else if (tp_nodata) begin
          nxt_st.term    = TERM_DISC_NODATA;
          nxt_st.frame_n = 1'b1;
          nxt_st.st      = S_REL;
        end else if (tp_ready) begin
          nxt_st.words = 3'h0;
          if (!st_ff.s2.stop_n) begin
            nxt_st.term     = TERM_DISC_DATA;
            nxt_st.last_blk = 1'b1;
          end
          if (!f_valid) begin
            nxt_st.frame_n = 1'b1;
            nxt_st.st      = S_REL;
          end else begin
            nxt_st.st = S_DATA;
            if (!st_ff.s2.stop_n || f_count <= BLOCK_CLKS) begin
              nxt_st.last_blk = 1'b1;
            end
          end
        end else if (tp_mabort) begin
          // words sent are lost; the fifo rest goes in a new access
          nxt_st.term    = TERM_MST_ABORT;
          nxt_st.frame_n = 1'b1;
          nxt_st.st      = S_REL;
        end
      end
      S_REL: begin
        nxt_st.frame_n    = 1'b1;
        nxt_st.frame_oe_n = 1'b1;
        nxt_st.irdy_n     = 1'b1;
        nxt_st.irdy_oe_n  = 1'b1;
        nxt_st.ad_oe_n    = 1'b1;
        nxt_st.cbe_oe_n   = 1'b1;
        nxt_st.cnt        = 4'h0;
        nxt_st.st         = S_TURN;
      end
      S_TURN: begin
        // bus looks idle a clock early; wait for stop to be let go
        if (st_ff.cnt >= TURN_CLKS && st_ff.s2.stop_n) begin
          nxt_st.term_valid = 1'b1;
          nxt_st.st         = S_IDLE;
        end
      end
      default: begin
        nxt_st.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff            <= '0;
      st_ff.st         <= S_IDLE;
      st_ff.s1         <= PINS_IDLE;
      st_ff.s2         <= PINS_IDLE;
      st_ff.frame_n    <= 1'b1;
      st_ff.frame_oe_n <= 1'b1;
      st_ff.irdy_n     <= 1'b1;
      st_ff.irdy_oe_n  <= 1'b1;
      st_ff.ad_oe_n    <= 1'b1;
      st_ff.cbe_n      <= 4'hF;
      st_ff.cbe_oe_n   <= 1'b1;
      st_ff.addr       <= ADDR_RST;
      st_ff.term       <= TERM_NORMAL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_frame_n    = st_ff.frame_n;
  assign o_frame_oe_n = st_ff.frame_oe_n;
  assign o_irdy_n     = st_ff.irdy_n;
  assign o_irdy_oe_n  = st_ff.irdy_oe_n;
  assign o_ad         = st_ff.ad;
  assign o_ad_oe_n    = st_ff.ad_oe_n;
  assign o_cbe_n      = st_ff.cbe_n;
  assign o_cbe_oe_n   = st_ff.cbe_oe_n;
  assign o_term       = st_ff.term;
  assign o_term_valid = st_ff.term_valid;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!rst_n);

  chk_start_wbf : assert property (
    $fell(o_frame_oe_n) |-> $past(st_ff.s2.wbf_n))
    else $error("transaction started with write buffer full");
  chk_tp_wait : assert property (
    (tp_live && st_ff.s2.trdy_n && st_ff.s2.stop_n && !tp_mabort)
      |=> (st_ff.st == S_TP))
    else $error("throttle point left without ready or stop");
  chk_stop_frame : assert property (
    tp_nodata |=> o_frame_n && !o_frame_oe_n ##1 o_frame_oe_n)
    else $error("frame not ended after refusal");
  chk_turn_free : assert property (
    (st_ff.st == S_TURN) |-> o_frame_oe_n && o_irdy_oe_n && o_ad_oe_n
      && o_cbe_oe_n)
    else $error("shared pins driven during turnaround");
  chk_tabort_end : assert property (
    tp_abort |=> o_frame_n ##[3:20] o_term_valid
      && o_term == TERM_TGT_ABORT)
    else $error("target abort not reported");
  chk_mabort_end : assert property (
    tp_mabort |=> o_frame_n ##[3:20] o_term_valid
      && o_term == TERM_MST_ABORT)
    else $error("master abort not reported");
  chk_one_qword : assert property (
    (st_ff.st == S_DATA && st_ff.last_blk && st_ff.words == 3'h0
      && f_count == 1) |=> o_frame_n && !o_irdy_n)
    else $error("single word block framing wrong");
  chk_first_data : assert property (
    $fell(o_frame_oe_n) |=> !o_irdy_n && (o_cbe_n == BE_ALL_N))
    else $error("first data not on clock after address");

  cov_normal : cover property (o_term_valid && o_term == TERM_NORMAL);
  cov_disc_data : cover property (
    o_term_valid && o_term == TERM_DISC_DATA);
  cov_disc_nodata : cover property (
    o_term_valid && o_term == TERM_DISC_NODATA);
  cov_mabort : cover property (o_term_valid && o_term == TERM_MST_ABORT);

endmodule

// ---- rtl/fw_host_pkg.sv ----
package fw_host_pkg;

  // ****************************************
  // bus encodings and timing counts
  // ****************************************
  localparam int           DATA_W        = 32;
  localparam int           FIFO_DEPTH    = 16;
  localparam logic [3:0]   CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0]   BE_ALL_N      = 4'h0;
  localparam logic [2:0]   BLOCK_CLKS    = 3'h4;
  localparam logic [3:0]   SLOW_DEC_CLK  = 4'h5;
  localparam logic [3:0]   SYNC_LAG      = 4'h2;
  localparam logic [3:0]   TURN_CLKS     = 4'h2;
  localparam logic [31:0]  ADDR_STEP     = 32'h4;
  localparam logic [31:0]  ADDR_RST      = 32'h0;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    S_IDLE,
    S_DATA,
    S_TP,
    S_REL,
    S_TURN
  } state_t;

  typedef enum logic [2:0] {
    TERM_NORMAL,
    TERM_DISC_DATA,
    TERM_DISC_NODATA,
    TERM_TGT_ABORT,
    TERM_MST_ABORT
  } term_t;

  // target-driven control pins, all active low
  typedef struct packed {
    logic devsel_n;
    logic trdy_n;
    logic stop_n;
    logic wbf_n;
  } tgt_pins_t;

  localparam tgt_pins_t PINS_IDLE = 4'hF;

endpackage
